/* File: hdl/dma_size_track.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dma_size_consts.svh"
module dma_size_track (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire dma_size_pkg::word_t  hwdata,
    output var  dma_size_pkg::word_t  hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 start_event,
    input  wire logic                 txn_done,
    input  wire logic [2:0]           txn_bytes,
    input  wire logic [7:0]           txn_data,
    output logic                      txn_req,
    output logic [2:0]                txn_len,
    output logic                      block_done
);
    import dma_size_pkg::*;

    logic [`ADDR_BITS-1:0] addr_q;
    logic                  wr_q;
    logic                  rd_q;
    logic [2:0]  ctrl_r;
    word_t       src_addr_r;
    logic [7:0]  ssize_r;
    logic [15:0] dsize_r;
    logic [7:0]  csize_r;
    logic [7:0]  pdat_r;
    logic [15:0] sptr_r;
    logic [15:0] sptr_nxt;
    logic [15:0] dptr_r;
    logic [15:0] dptr_nxt;
    logic [7:0]  cptr_r;
    logic [16:0] moved_r;
    logic [16:0] cell_moved_r;
    logic        pmatch_r;
    chan_state_t state_r;

    logic        xm;
    logic [16:0] src_bytes;
    logic [16:0] dst_bytes;
    logic [16:0] blk_bytes;
    logic [16:0] cell_bytes;
    logic [16:0] cell_left;
    logic [16:0] blk_left;
    logic [16:0] step;
    logic        match;
    logic        ssa_wr;
    logic        cell_end;
    logic        blk_end;

    // zero encodes one full range: 256 bytes for 8 bits, 65536 for 16
    function automatic logic [16:0] size_of(input logic [15:0] v, input logic wide);
        logic [16:0] r;
        r = 17'h0;
        if (wide)
            r = (v == 16'h0) ? 17'h10000 : {1'b0, v};
        else
            r = (v[7:0] == 8'h0) ? 17'h00100 : {9'h0, v[7:0]};
        return r;
    endfunction : size_of

    function automatic logic [16:0] min17(input logic [16:0] a, input logic [16:0] b);
        return (a < b) ? a : b;
    endfunction : min17

    // one transaction carries at most one word
    function automatic logic [2:0] len_of(input logic [16:0] left);
        logic [2:0] r;
        r = (left > 17'd4) ? 3'd4 : left[2:0];
        return r;
    endfunction : len_of

    assign xm         = ctrl_r[`CTRL_XM_BIT];
    // normal mode: byte count in the low byte; extended: the field is the upper byte
    assign src_bytes  = xm ? size_of({ssize_r, 8'h00}, 1'b1)
                           : size_of({8'h00, ssize_r}, 1'b0);
    assign dst_bytes  = size_of(dsize_r, xm);
    assign blk_bytes  = (src_bytes > dst_bytes) ? src_bytes : dst_bytes;
    assign cell_bytes = xm ? blk_bytes : size_of({8'h00, csize_r}, 1'b0);
    assign blk_left   = blk_bytes - moved_r;
    assign cell_left  = min17(cell_bytes - cell_moved_r, blk_left);
    assign step       = {14'h0, txn_bytes};
    assign match      = ctrl_r[`CTRL_PAT_BIT] && txn_done && (txn_data == pdat_r);
    assign ssa_wr     = wr_q && (addr_q == `OFF_SSA);
    assign cell_end   = txn_done && (step >= cell_left);
    assign blk_end    = txn_done && ((step >= blk_left) || match);

    // bus address phase capture, zero-wait slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
        end else begin
            wr_q   <= hsel && hready && htrans[1] && hwrite;
            rd_q   <= hsel && hready && htrans[1] && !hwrite;
            addr_q <= haddr[`ADDR_BITS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // the slave never signals an error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r     <= 3'h0;
            src_addr_r <= 32'h0;
            ssize_r    <= 8'h00;
            dsize_r    <= 16'h0000;
            csize_r    <= 8'h00;
            pdat_r     <= 8'h00;
        end else if (wr_q) begin
            case (addr_q)
                `OFF_CTRL:  ctrl_r     <= hwdata[2:0];
                `OFF_SSA:   src_addr_r <= hwdata;
                `OFF_SSIZE: ssize_r    <= hwdata[7:0];
                // upper byte only writable in extended mode
                `OFF_DSIZE: dsize_r    <= xm ? hwdata[15:0] : {dsize_r[15:8], hwdata[7:0]};
                `OFF_CSIZE: csize_r    <= hwdata[7:0];
                `OFF_PDAT:  pdat_r     <= hwdata[7:0];
                default:    ctrl_r     <= ctrl_r;
            endcase
        end
    end

    // read data registered in the data phase; ack same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[`ADDR_BITS-1:0])
                `OFF_CTRL:   hrdata <= {29'h0, ctrl_r};
                `OFF_SSA:    hrdata <= src_addr_r;
                `OFF_SSIZE:  hrdata <= {24'h0, ssize_r};
                `OFF_DSIZE:  hrdata <= {16'h0, xm ? dsize_r[15:8] : 8'h00, dsize_r[7:0]};
                `OFF_SPTR:   hrdata <= {24'h0, xm ? sptr_r[15:8] : sptr_r[7:0]};
                `OFF_DPTR:   hrdata <= {16'h0, xm ? dptr_r[15:8] : 8'h00, dptr_r[7:0]};
                `OFF_CSIZE:  hrdata <= {24'h0, csize_r};
                `OFF_CPTR:   hrdata <= {24'h0, xm ? 8'h00 : cptr_r};
                `OFF_PDAT:   hrdata <= {24'h0, pdat_r};
                `OFF_STATUS: hrdata <= {29'h0, pmatch_r, block_done, state_r != ST_IDLE};
                default:     hrdata <= 32'h0;
            endcase
        end else begin
            hrdata <= 32'h0;
        end
    end

    // channel sequencing per triggering event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE:     if (start_event) state_r <= ST_CELL;
                ST_CELL:     if (blk_end) state_r <= ctrl_r[`CTRL_AUTO_BIT] ? ST_WAIT_EVT : ST_IDLE;
                             else if (cell_end) state_r <= ST_WAIT_EVT;
                ST_WAIT_EVT: if (start_event) state_r <= ST_CELL;
                default:     state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txn_req <= 1'b0;
            txn_len <= 3'h0;
        end else begin
            txn_req <= (state_r == ST_CELL) && !cell_end && !blk_end;
            // a finishing transaction is taken off the remainder now, so the next length is not stale
            txn_len <= len_of(txn_done ? cell_left - step : cell_left);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            block_done <= 1'b0;
        end else begin
            block_done <= (state_r == ST_CELL) && blk_end;
        end
    end

    // set wins over the clear by a new event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pmatch_r <= 1'b0;
        end else begin
            if (match)
                pmatch_r <= 1'b1;
            else if (start_event)
                pmatch_r <= 1'b0;
        end
    end

    // source pointer wraps at source size
    always_comb begin
        sptr_nxt = sptr_r;
        if (ssa_wr || match || blk_end) begin
            sptr_nxt = 16'h0;
        end else if (txn_done && state_r == ST_CELL) begin
            if ({1'b0, sptr_r} + step >= src_bytes)
                sptr_nxt = 16'h0;
            else
                sptr_nxt = sptr_r + {13'h0, txn_bytes};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sptr_r <= 16'h0;
        end else begin
            sptr_r <= sptr_nxt;
        end
    end

    // destination pointer wraps at destination size
    always_comb begin
        dptr_nxt = dptr_r;
        if (blk_end || match) begin
            dptr_nxt = 16'h0;
        end else if (txn_done && state_r == ST_CELL) begin
            if ({1'b0, dptr_r} + step >= dst_bytes)
                dptr_nxt = 16'h0;
            else
                dptr_nxt = dptr_r + {13'h0, txn_bytes};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dptr_r <= 16'h0;
        end else begin
            dptr_r <= dptr_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cptr_r       <= 8'h00;
            cell_moved_r <= 17'h0;
        end else begin
            if (start_event && state_r != ST_CELL) begin
                cptr_r       <= 8'h00;
                cell_moved_r <= 17'h0;
            end else if (txn_done && state_r == ST_CELL) begin
                cptr_r       <= cptr_r + {5'h0, txn_bytes};
                cell_moved_r <= cell_moved_r + step;
            end
        end
    end

    // block progress survives a new source address; only the block end restarts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            moved_r <= 17'h0;
        end else begin
            if (blk_end)
                moved_r <= 17'h0;
            else if (txn_done && state_r == ST_CELL)
                moved_r <= moved_r + step;
        end
    end
endmodule : dma_size_track
`default_nettype wire

/* File: pkg/dma_size_consts.svh */
`ifndef DMA_SIZE_CONSTS_SVH
`define DMA_SIZE_CONSTS_SVH
`define OFF_CTRL        8'h00
`define OFF_SSA         8'h04
`define OFF_SSIZE       8'h08
`define OFF_DSIZE       8'h0c
`define OFF_SPTR        8'h10
`define OFF_DPTR        8'h14
`define OFF_CSIZE       8'h18
`define OFF_CPTR        8'h1c
`define OFF_PDAT        8'h20
`define OFF_STATUS      8'h24
`define CTRL_XM_BIT     0
`define CTRL_PAT_BIT    1
`define CTRL_AUTO_BIT   2
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_PMATCH_BIT 2
`define ADDR_BITS       8
`endif

/* File: pkg/dma_size_pkg.sv */
package dma_size_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CELL,
        ST_WAIT_EVT
    } chan_state_t;
    typedef logic [31:0] word_t;
endpackage : dma_size_pkg

/* File: verif/dma_size_track_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dma_size_consts.svh"
module dma_size_track_monitor (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire dma_size_pkg::word_t hrdata,
    input wire logic                start_event,
    input wire logic                txn_done,
    input wire logic                txn_req,
    input wire logic [2:0]          txn_len,
    input wire logic                block_done
);
    import dma_size_pkg::*;
    logic       rd_r;
    logic [7:0] ra_r;
    // remembers which read owns the current data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_r <= 1'b0;
            ra_r <= 8'h00;
        end else begin
            rd_r <= hsel && hready && htrans[1] && !hwrite;
            ra_r <= haddr[7:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    byte_regs_a: assert property (rd_r && ra_r inside {`OFF_SSIZE, `OFF_SPTR, `OFF_CSIZE, `OFF_CPTR, `OFF_PDAT}
        |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
    half_regs_a: assert property (rd_r && ra_r inside {`OFF_DSIZE, `OFF_DPTR} |-> hrdata[31:16] == 16'h0)
        else $error("upper half set");
    rdata_idle_a: assert property (!rd_r |-> hrdata == 32'h0) else $error("stale read data");
    unmapped_a: assert property (rd_r && ra_r > `OFF_STATUS |-> hrdata == 32'h0) else $error("unmapped read");
    txn_len_a: assert property (txn_req |-> txn_len inside {[3'h1:3'h4]}) else $error("bad length");
    done_pulse_a: assert property (block_done |=> !block_done) else $error("long done");
    done_cause_a: assert property (block_done |-> $past(txn_done)) else $error("done without txn");
    req_start_a: assert property ($rose(txn_req) |-> $past(start_event) || $past(start_event, 2))
        else $error("req without event");
endmodule : dma_size_track_monitor
bind dma_size_track dma_size_track_monitor i_dma_size_track_monitor (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .start_event(start_event), .txn_done(txn_done), .txn_req(txn_req), .txn_len(txn_len), .block_done(block_done));
`default_nettype wire

/* File: verif/txn_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module txn_engine_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       txn_req,
    input  wire logic [2:0] txn_len,
    input  wire logic [1:0] gap,
    output logic            txn_done,
    output logic [2:0]      txn_bytes,
    output logic [7:0]      txn_data
);
    logic [7:0] seq_r;
    logic [1:0] wait_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txn_done  <= 1'b0;
            txn_bytes <= 3'h0;
            txn_data  <= 8'h00;
            seq_r     <= 8'h00;
            wait_r    <= 2'h0;
        end else if (!txn_done && txn_req && wait_r == 2'h0) begin
            txn_done  <= 1'b1;
            txn_bytes <= txn_len;
            txn_data  <= seq_r;
            seq_r     <= seq_r + 8'h01;
            wait_r    <= gap;
        end else begin
            // qualifiers go stale outside a pulse
            txn_done  <= 1'b0;
            txn_bytes <= ~txn_bytes;
            txn_data  <= ~txn_data;
            if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
        end
    end
endmodule : txn_engine_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dma_size_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("mismatch %0t %h %h", $time, a, e); end end
module tb;
    import dma_size_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, start_event = 1'b0, bd = 1'b0;
    logic        hreadyout, hresp, txn_done, txn_req, block_done;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0, gap = 2'h0;
    logic [2:0]  txn_bytes, txn_len;
    logic [7:0]  txn_data, nt = 8'h0, tot = 8'h0;
    word_t       hwdata = 32'h0, hrdata, rv;
    int          n_fail = 0, check_count = 0, cyc = 0, nb = 0;
    dma_size_track i_dma_size_track (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .start_event(start_event), .txn_done(txn_done), .txn_bytes(txn_bytes), .txn_data(txn_data),
        .txn_req(txn_req), .txn_len(txn_len), .block_done(block_done));
    txn_engine_model i_txn_engine_model (.hclk(hclk), .hresetn(hresetn), .txn_req(txn_req), .txn_len(txn_len),
        .gap(gap), .txn_done(txn_done), .txn_bytes(txn_bytes), .txn_data(txn_data));
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (block_done === 1'b1) bd = 1'b1;
        if (txn_done === 1'b1) begin
            nb += txn_bytes;
            nt++;
            tot++;
        end
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("fails %0d checks %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic bus(input logic w, input logic [7:0] a, input word_t d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : bus
    task automatic chk(input logic [7:0] a, input word_t e);
        bus(1'b0, a, 32'h0);
        `CHK(rv, e)
    endtask : chk
    task automatic setup(input word_t c, s, d, z, p);
        bus(1'b1, `OFF_CTRL, c);
        bus(1'b1, `OFF_SSIZE, s);
        bus(1'b1, `OFF_DSIZE, d);
        bus(1'b1, `OFF_CSIZE, z);
        bus(1'b1, `OFF_PDAT, p);
    endtask : setup
    task automatic fire();
        @(posedge hclk);
        nb = 0;
        nt = 8'h0;
        bd = 1'b0;
        start_event <= 1'b1;
        @(posedge hclk);
        start_event <= 1'b0;
        for (int i = 0; i < 2000 && (i < 3 || txn_req === 1'b1); i++) @(posedge hclk);
        repeat (3) @(posedge hclk);
    endtask : fire
    task automatic t_regs();
        chk(`OFF_SPTR, 32'h0);
        chk(`OFF_DPTR, 32'h0);
        chk(`OFF_CPTR, 32'h0);
        setup(32'h0, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff);
        chk(`OFF_SSIZE, 32'hff);
        chk(`OFF_DSIZE, 32'hff);
        chk(`OFF_PDAT, 32'hff);
        bus(1'b1, `OFF_SPTR, 32'hffffffff);
        chk(`OFF_SPTR, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        chk(8'h40, 32'h0);
    endtask : t_regs
    task automatic t_cell();
        setup(32'h0, 32'h6, 32'h4, 32'h4, 32'h0);
        fire();
        `CHK(nb, 4)
        `CHK(bd, 1'b0)
        chk(`OFF_CPTR, 32'h4);
        chk(`OFF_SPTR, 32'h4);
        chk(`OFF_DPTR, 32'h0);
        bus(1'b1, `OFF_SSA, 32'h100);
        chk(`OFF_SPTR, 32'h0);
        fire();
        `CHK(bd, 1'b1)
    endtask : t_cell
    task automatic t_pat();
        setup(32'h2, 32'h0, 32'h0, 32'h0, {24'h0, tot + 8'h02});
        fire();
        `CHK(nt, 8'h03)
        chk(`OFF_SPTR, 32'h0);
        setup(32'h0, 32'h0, 32'h0, 32'h0, {24'h0, tot + 8'h02});
        fire();
        `CHK(nb, 256)
        `CHK(bd, 1'b1)
    endtask : t_pat
    task automatic t_ext();
        gap <= 2'h2;
        setup(32'h1, 32'h1, 32'h2, 32'h3, 32'h0);
        fire();
        `CHK(nb, 256)
        `CHK(bd, 1'b1)
        chk(`OFF_CPTR, 32'h0);
        bus(1'b1, `OFF_DSIZE, 32'hffffffff);
        chk(`OFF_DSIZE, 32'hffff);
    endtask : t_ext
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_cell();
        t_pat();
        t_ext();
        stop_test();
    end
endmodule : tb
`default_nettype wire
